// >>> hdl/rsc_pkg.sv
// Package: constants, types and carriers of the routing snapshot controller
package rsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int SEC_CYC = CLK_HZ;
  localparam logic [2:0] MENU_TO_S = 3'h5;
  localparam logic [2:0] FAULT_HOLD_S = 3'h3;
  localparam logic [2:0] LOCK_FLASH_S = 3'h2;

  // ----------------------------------------------------------------
  // Value ranges
  // ----------------------------------------------------------------
  // Trim counts half-dB steps, two's complement
  localparam logic [6:0] TRIM_MAX = 7'h27;
  localparam logic [6:0] TRIM_MIN = 7'h59;
  localparam logic [3:0] TOP_LAST = 4'h5;
  localparam logic [3:0] SLOT_LAST = 4'h9;
  localparam logic [3:0] SLOT_USER0 = 4'h1;
  localparam logic [3:0] BOOT_SLOT = 4'h1;
  localparam logic [3:0] CLR_CONFIRM = 4'h2;
  localparam logic [1:0] BRT_MIN = 2'h1;
  localparam logic [1:0] BRT_MAX = 2'h3;
  localparam logic [1:0] BRT_RST = 2'h3;
  localparam logic [7:0] VAL_DASH = 8'hFF;
  localparam logic [3:0] SAMPLE_MIC = 4'h5;
  localparam logic [3:0] SAMPLE_PRE = 4'hA;

  // ----------------------------------------------------------------
  // Top menu entries and register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] E_ADD = 4'h0;
  localparam logic [3:0] E_LOAD = 4'h1;
  localparam logic [3:0] E_CLR = 4'h2;
  localparam logic [3:0] E_RMIC = 4'h3;
  localparam logic [3:0] E_RPRE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_TRIM = 4'h8;
  localparam logic [3:0] REG_SNAP = 4'hC;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0][6:0] trim;
    logic [3:0][1:0] route_mic;
    logic [3:0] route_on;
    logic [3:0] lock;
    logic [3:0] rl_mic;
    logic [3:0] rl_pre;
    logic rmode;
    logic [1:0] brt;
    logic [1:0] sel_mic;
    logic [1:0] sel_pre;
    logic sel_mv;
    logic sel_pv;
  } rsc_cfg_t;

  localparam rsc_cfg_t CFG_RST = '{brt: BRT_RST, default: '0};

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_TOP = 8'h02, ST_ADD = 8'h04, ST_LOAD = 8'h08,
    ST_CLR = 8'h10, ST_RMIC = 8'h20, ST_RPRE = 8'h40, ST_BRT = 8'h80
  } rsc_state_t;

  typedef enum logic [3:0] {
    DC_TRIM = 4'h0, DC_FAULT = 4'h1, DC_BLANK = 4'h2, DC_DASH = 4'h3,
    DC_MENU = 4'h4, DC_ADD = 4'h5, DC_LOAD = 4'h6, DC_CLR = 4'h7,
    DC_RMIC = 4'h8, DC_RPRE = 4'h9, DC_BRT = 4'hA
  } rsc_disp_t;

  typedef struct packed {
    logic [3:0] mic;
    logic [3:0] pre;
    logic lock;
    logic ph;
    logic push;
    logic enc_a;
    logic enc_b;
    logic remote;
    logic [3:0] ext_ph;
  } rsc_pin_t;

  typedef struct packed {
    logic [3:0] mic_led;
    logic [3:0] pre_led;
    logic lock_led;
    logic [3:0] ph_en;
    logic [3:0] route_on;
    logic [7:0] route_mic;
    logic [3:0] mute;
    logic [1:0] mon_pre;
    logic [6:0] mon_trim;
    rsc_disp_t disp;
    logic [7:0] disp_val;
    logic disp_dp;
    logic plus_up;
    logic plus_lo;
    logic [1:0] led_level;
    logic rmode;
  } rsc_out_t;

endpackage

// >>> hdl/rsc_top.sv
// Routing, phantom, trim, snapshot and menu control of the audition switcher
module rsc_top
  import rsc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic FIRST_BOOT,
  input wire logic [3:0] MIC_BTN,
  input wire logic [3:0] PRE_BTN,
  input wire logic LOCK_BTN,
  input wire logic PHANTOM_BTN,
  input wire logic ENC_PUSH,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic REMOTE_BTN,
  input wire logic [3:0] EXT_PHANTOM,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic [3:0] MIC_LED,
  output logic [3:0] PRE_LED,
  output logic LOCK_LED,
  output logic [3:0] PHANTOM_EN,
  output logic [3:0] ROUTE_ON,
  output logic [7:0] ROUTE_MIC,
  output logic [3:0] PRE_MUTE,
  output logic [1:0] MON_PRE,
  output logic [6:0] MON_TRIM,
  output logic [3:0] DISP_CODE,
  output logic [7:0] DISP_VAL,
  output logic DISP_DP,
  output logic PLUS_UP,
  output logic PLUS_LO,
  output logic [1:0] LED_LEVEL,
  output logic REMOTE_MODE
);

  localparam logic [25:0] SEC_LAST = 26'(SEC_CYCLES - 1);
  localparam logic [25:0] SEC_HALF = 26'(SEC_CYCLES / 2);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] step_wrap(input logic [3:0] v, input logic [3:0] lo,
                                           input logic [3:0] hi, input logic up);
    if (up) begin
      return (v >= hi) ? lo : v + 4'h1;
    end
    return (v <= lo) ? hi : v - 4'h1;
  endfunction

  // Next list member after cur, found flag on top
  function automatic logic [2:0] next_member(input logic [3:0] list, input logic [1:0] cur);
    logic [2:0] r;
    logic [1:0] k;
    r = {1'b0, cur};
    for (int i = 3; i >= 1; i--) begin
      k = cur + 2'(i);
      if (list[k]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] first_set(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic route_ok(input rsc_cfg_t c, input logic [1:0] m,
                                    input logic [1:0] p);
    logic ok;
    ok = !(c.lock[p] && !(c.route_on[p] && c.route_mic[p] == m));
    for (int q = 0; q < 4; q++) begin
      if (2'(q) != p && c.lock[q] && c.route_on[q] && c.route_mic[q] == m) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rsc_pin_t pin_raw, s1_r, s2_r, s3_r, rise;
  rsc_cfg_t cfg_r, cfg_nxt;
  rsc_cfg_t mem [1:9];
  rsc_state_t st_r, st_nxt;
  rsc_out_t out_r, out_nxt;
  logic [25:0] sec_r;
  logic [2:0] to_r, to_nxt, lf_r, lf_nxt, fh_r, fh_nxt;
  logic [3:0] sel_r, sel_nxt, ph_r, ph_nxt;
  logic [9:0] used_r, used_nxt;
  logic dash_r, dash_nxt, boot_r;
  logic [31:0] rdata_r;
  logic mem_we;
  logic [3:0] mem_wa;

  // Pins cross into the clock domain through two flops, third is edge history
  assign pin_raw = '{mic: MIC_BTN, pre: PRE_BTN, lock: LOCK_BTN, ph: PHANTOM_BTN,
                     push: ENC_PUSH, enc_a: ENC_A, enc_b: ENC_B,
                     remote: REMOTE_BTN, ext_ph: EXT_PHANTOM};
  assign rise = s2_r & ~s3_r;

  wire sec_tick = (sec_r == SEC_LAST);
  wire blink = (sec_r >= SEC_HALF);
  wire [3:0] fault = s2_r.ext_ph;
  wire enc_step = rise.enc_a;
  wire enc_up = !s2_r.enc_b;
  wire any_evt = (|rise.mic) || (|rise.pre) || rise.lock || rise.push || enc_step
                 || rise.remote;
  wire [3:0] trim_idx = {cfg_r.sel_mic, cfg_r.sel_pre};
  wire [6:0] trim_cur = cfg_r.trim[trim_idx];
  wire pair_sel = cfg_r.sel_mv && cfg_r.sel_pv;
  wire pair_routed = pair_sel && cfg_r.route_on[cfg_r.sel_pre]
                     && cfg_r.route_mic[cfg_r.sel_pre] == cfg_r.sel_mic;
  wire cur_lock = pair_routed && cfg_r.lock[cfg_r.sel_pre];
  wire [1:0] mic_hit = first_set(rise.mic);
  wire [1:0] pre_hit = first_set(rise.pre);
  wire [2:0] rem_mic = next_member(cfg_r.rl_mic, cfg_r.sel_mic);
  wire [2:0] rem_pre = next_member(cfg_r.rl_pre, cfg_r.sel_pre);
  wire in_menu = (st_r != ST_IDLE);
  wire reg_wr_ctrl = REG_WR && REG_ADDR == REG_CTRL;
  wire [1:0] wr_brt = REG_WDATA[1:0];

  logic [3:0] mic_lk;
  for (genvar g = 0; g < 4; g++) begin : g_mic_lock
    assign mic_lk[g] = (cfg_r.lock[0] && cfg_r.route_on[0] && cfg_r.route_mic[0] == 2'(g))
                    || (cfg_r.lock[1] && cfg_r.route_on[1] && cfg_r.route_mic[1] == 2'(g))
                    || (cfg_r.lock[2] && cfg_r.route_on[2] && cfg_r.route_mic[2] == 2'(g))
                    || (cfg_r.lock[3] && cfg_r.route_on[3] && cfg_r.route_mic[3] == 2'(g));
  end

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  wire [31:0] rd_status = {8'h00, ph_r, fault, cfg_r.lock, cfg_r.route_on, cfg_r.route_mic};
  wire [31:0] rd_ctrl = {29'h0, cfg_r.rmode, cfg_r.brt};
  wire [31:0] rd_trim = {25'h0, trim_cur};
  wire [31:0] rd_snap = {22'h0, used_r};
  wire [31:0] rd_mux = (REG_ADDR == REG_STATUS) ? rd_status :
                       (REG_ADDR == REG_CTRL) ? rd_ctrl :
                       (REG_ADDR == REG_TRIM) ? rd_trim :
                       (REG_ADDR == REG_SNAP) ? rd_snap : 32'h0;

  // ----------------------------------------------------------------
  // Control and menu
  // ----------------------------------------------------------------
  logic req, req_mv, req_pv;
  logic [1:0] req_m, req_p;

  always_comb begin
    cfg_nxt = cfg_r;
    st_nxt = st_r;
    sel_nxt = sel_r;
    dash_nxt = dash_r;
    ph_nxt = ph_r;
    used_nxt = used_r;
    to_nxt = to_r;
    lf_nxt = (sec_tick && lf_r != 3'h0) ? lf_r - 3'h1 : lf_r;
    fh_nxt = (|fault) ? FAULT_HOLD_S :
             (sec_tick && fh_r != 3'h0) ? fh_r - 3'h1 : fh_r;
    mem_we = 1'b0;
    mem_wa = sel_r;
    req = 1'b0;
    req_m = cfg_r.sel_mic;
    req_p = cfg_r.sel_pre;
    req_mv = cfg_r.sel_mv;
    req_pv = cfg_r.sel_pv;
    if (reg_wr_ctrl) begin
      cfg_nxt.rmode = REG_WDATA[2];
      if (wr_brt >= BRT_MIN) begin
        cfg_nxt.brt = wr_brt;
      end
    end
    if (in_menu) begin
      if (any_evt) begin
        to_nxt = MENU_TO_S;
      end else if (sec_tick) begin
        to_nxt = to_r - 3'h1;
        if (to_r <= 3'h1) begin
          st_nxt = ST_IDLE;
        end
      end
    end
    case (st_r)
      ST_IDLE: begin
        if (rise.push) begin
          st_nxt = ST_TOP;
          dash_nxt = 1'b1;
          to_nxt = MENU_TO_S;
        end else if (|rise.mic) begin
          if (s2_r.ph) begin
            ph_nxt[mic_hit] = !ph_r[mic_hit];
          end else begin
            req = 1'b1;
            req_m = mic_hit;
            req_mv = 1'b1;
          end
        end else if ((|rise.pre) && !fault[pre_hit]) begin
          req = 1'b1;
          req_p = pre_hit;
          req_pv = 1'b1;
        end else if (rise.lock) begin
          if (pair_routed) begin
            cfg_nxt.lock[cfg_r.sel_pre] = !cfg_r.lock[cfg_r.sel_pre];
          end
        end else if (enc_step && pair_sel) begin
          if (enc_up && trim_cur != TRIM_MAX) begin
            cfg_nxt.trim[trim_idx] = trim_cur + 7'h01;
          end else if (!enc_up && trim_cur != TRIM_MIN) begin
            cfg_nxt.trim[trim_idx] = trim_cur - 7'h01;
          end
        end else if (rise.remote) begin
          if (!cfg_r.rmode && rem_mic[2]) begin
            req = 1'b1;
            req_m = rem_mic[1:0];
            req_mv = 1'b1;
          end else if (cfg_r.rmode && rem_pre[2] && !fault[rem_pre[1:0]]) begin
            req = 1'b1;
            req_p = rem_pre[1:0];
            req_pv = 1'b1;
          end
        end
      end
      ST_TOP: begin
        if (enc_step) begin
          sel_nxt = dash_r ? E_ADD : step_wrap(sel_r, E_ADD, TOP_LAST, enc_up);
          dash_nxt = 1'b0;
        end else if (rise.push) begin
          dash_nxt = 1'b1;
          st_nxt = ST_IDLE;
          if (!dash_r) begin
            case (sel_r)
              E_ADD: st_nxt = ST_ADD;
              E_LOAD: st_nxt = ST_LOAD;
              E_CLR: st_nxt = ST_CLR;
              E_RMIC: begin
                st_nxt = ST_RMIC;
                cfg_nxt.rmode = 1'b0;
              end
              E_RPRE: begin
                st_nxt = ST_RPRE;
                cfg_nxt.rmode = 1'b1;
              end
              default: st_nxt = ST_BRT;
            endcase
          end
        end
      end
      ST_ADD: begin
        if (enc_step) begin
          sel_nxt = dash_r ? SLOT_USER0 : step_wrap(sel_r, SLOT_USER0, SLOT_LAST, enc_up);
          dash_nxt = 1'b0;
        end else if (rise.push) begin
          st_nxt = ST_IDLE;
          if (!dash_r) begin
            mem_we = 1'b1;
            used_nxt[sel_r] = 1'b1;
          end
        end
      end
      ST_LOAD: begin
        if (enc_step) begin
          sel_nxt = dash_r ? 4'h0 : step_wrap(sel_r, 4'h0, SLOT_LAST, enc_up);
          dash_nxt = 1'b0;
        end else if (rise.push) begin
          st_nxt = ST_IDLE;
          if (!dash_r && sel_r != 4'h0 && used_r[sel_r]) begin
            cfg_nxt = mem[sel_r];
          end else if (!dash_r) begin
            cfg_nxt.route_on = 4'h0;
            cfg_nxt.lock = 4'h0;
            cfg_nxt.trim = '0;
          end
        end
      end
      ST_CLR: begin
        if (enc_step) begin
          sel_nxt = dash_r ? 4'h1 : CLR_CONFIRM;
          dash_nxt = 1'b0;
        end else if (rise.push) begin
          st_nxt = ST_IDLE;
          if (!dash_r && sel_r == CLR_CONFIRM) begin
            used_nxt = 10'h000;
          end
        end
      end
      ST_RMIC: begin
        if (|rise.mic) begin
          if (cfg_r.rl_mic[mic_hit] || !mic_lk[mic_hit]) begin
            cfg_nxt.rl_mic[mic_hit] = !cfg_r.rl_mic[mic_hit];
          end
        end else if (rise.push) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_RPRE: begin
        if (|rise.pre) begin
          cfg_nxt.rl_pre[pre_hit] = !cfg_r.rl_pre[pre_hit];
        end else if (rise.push) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_BRT: begin
        if (enc_step) begin
          cfg_nxt.brt = 2'(step_wrap({2'h0, cfg_r.brt}, {2'h0, BRT_MIN}, {2'h0, BRT_MAX},
                                     enc_up));
        end else if (rise.push) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (req) begin
      if (req_mv && req_pv) begin
        if (route_ok(cfg_r, req_m, req_p)) begin
          cfg_nxt.route_mic[req_p] = req_m;
          cfg_nxt.route_on[req_p] = 1'b1;
          cfg_nxt.sel_mic = req_m;
          cfg_nxt.sel_pre = req_p;
          cfg_nxt.sel_mv = 1'b1;
          cfg_nxt.sel_pv = 1'b1;
        end else begin
          lf_nxt = LOCK_FLASH_S;
        end
      end else begin
        cfg_nxt.sel_mic = req_m;
        cfg_nxt.sel_pre = req_p;
        cfg_nxt.sel_mv = req_mv;
        cfg_nxt.sel_pv = req_pv;
      end
    end
    if (boot_r) begin
      st_nxt = ST_IDLE;
      if (used_r[BOOT_SLOT]) begin
        cfg_nxt = mem[BOOT_SLOT];
      end
    end
    cfg_nxt.route_on = cfg_nxt.route_on & ~fault;
    cfg_nxt.lock = cfg_nxt.lock & ~fault;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    out_nxt = '0;
    out_nxt.ph_en = ph_r;
    out_nxt.route_on = cfg_r.route_on & ~fault;
    out_nxt.route_mic = cfg_r.route_mic;
    out_nxt.mute = fault;
    out_nxt.mon_pre = cfg_r.sel_pre;
    out_nxt.mon_trim = trim_cur;
    out_nxt.led_level = cfg_r.brt;
    out_nxt.rmode = cfg_r.rmode;
    out_nxt.plus_up = in_menu ? blink : (trim_cur != 7'h00 && !trim_cur[6]);
    out_nxt.plus_lo = in_menu ? !blink : (trim_cur != 7'h00 && !trim_cur[6]);
    out_nxt.disp_val = dash_r ? VAL_DASH : {4'h0, sel_r};
    case (st_r)
      ST_IDLE: begin
        if (s2_r.ph) begin
          out_nxt.mic_led = {4{blink}};
        end else if (cfg_r.sel_mv) begin
          out_nxt.mic_led = 4'h1 << cfg_r.sel_mic;
        end
        out_nxt.pre_led = (fault & {4{blink}}) |
                          ((cfg_r.sel_pv && !fault[cfg_r.sel_pre]) ?
                           (4'h1 << cfg_r.sel_pre) : 4'h0);
        out_nxt.lock_led = (lf_r != 3'h0) ? blink : cur_lock;
        if ((|fault) || fh_r != 3'h0) begin
          out_nxt.disp = blink ? DC_FAULT : DC_BLANK;
        end else begin
          out_nxt.disp = DC_TRIM;
        end
        out_nxt.disp_val = {trim_cur[6], trim_cur};
      end
      ST_TOP: out_nxt.disp = dash_r ? DC_DASH : DC_MENU;
      ST_ADD: begin
        out_nxt.disp = DC_ADD;
        out_nxt.disp_dp = !dash_r && used_r[sel_r];
      end
      ST_LOAD: begin
        out_nxt.disp = DC_LOAD;
        out_nxt.disp_dp = !dash_r && used_r[sel_r];
      end
      ST_CLR: out_nxt.disp = DC_CLR;
      ST_RMIC: begin
        out_nxt.disp = DC_RMIC;
        out_nxt.disp_dp = 1'b1;
        out_nxt.mic_led = cfg_r.rl_mic;
      end
      ST_RPRE: begin
        out_nxt.disp = DC_RPRE;
        out_nxt.disp_dp = 1'b1;
        out_nxt.pre_led = cfg_r.rl_pre;
      end
      ST_BRT: begin
        out_nxt.disp = DC_BRT;
        out_nxt.disp_val = {6'h00, cfg_r.brt};
        out_nxt.mic_led = SAMPLE_MIC;
        out_nxt.pre_led = SAMPLE_PRE;
        out_nxt.lock_led = 1'b1;
      end
      default: out_nxt.disp = DC_BLANK;
    endcase
  end

  // ----------------------------------------------------------------
  // Flops
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      sec_r <= 26'h0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      sec_r <= sec_tick ? 26'h0 : sec_r + 26'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_r <= CFG_RST;
      st_r <= ST_IDLE;
      sel_r <= 4'h0;
      dash_r <= 1'b1;
      ph_r <= 4'h0;
      to_r <= 3'h0;
      lf_r <= 3'h0;
      fh_r <= 3'h0;
      boot_r <= 1'b1;
      out_r <= '0;
      rdata_r <= 32'h0;
    end else begin
      cfg_r <= cfg_nxt;
      st_r <= st_nxt;
      sel_r <= sel_nxt;
      dash_r <= dash_nxt;
      ph_r <= ph_nxt;
      to_r <= to_nxt;
      lf_r <= lf_nxt;
      fh_r <= fh_nxt;
      boot_r <= 1'b0;
      out_r <= out_nxt;
      rdata_r <= REG_RD ? rd_mux : 32'h0;
    end
  end

  // Slot flags and contents model non-volatile storage: a plain reset keeps them, a first boot clears the flags only
  always_ff @(posedge CLK) begin
    if (RST && FIRST_BOOT) begin
      used_r <= 10'h000;
    end else if (!RST) begin
      used_r <= used_nxt;
    end
    if (mem_we && !RST) begin
      mem[mem_wa] <= cfg_r;
    end
  end

  assign REG_RDATA = rdata_r;
  assign MIC_LED = out_r.mic_led;
  assign PRE_LED = out_r.pre_led;
  assign LOCK_LED = out_r.lock_led;
  assign PHANTOM_EN = out_r.ph_en;
  assign ROUTE_ON = out_r.route_on;
  assign ROUTE_MIC = out_r.route_mic;
  assign PRE_MUTE = out_r.mute;
  assign MON_PRE = out_r.mon_pre;
  assign MON_TRIM = out_r.mon_trim;
  assign DISP_CODE = out_r.disp;
  assign DISP_VAL = out_r.disp_val;
  assign DISP_DP = out_r.disp_dp;
  assign PLUS_UP = out_r.plus_up;
  assign PLUS_LO = out_r.plus_lo;
  assign LED_LEVEL = out_r.led_level;
  assign REMOTE_MODE = out_r.rmode;

endmodule

// >>> verif/rsc_props.sv
// Port-level assertions of the routing snapshot controller
module rsc_props
  import rsc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PHANTOM_BTN,
  input wire logic [3:0] EXT_PHANTOM,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic [3:0] MIC_LED,
  input wire logic [3:0] PRE_LED,
  input wire logic LOCK_LED,
  input wire logic [3:0] PHANTOM_EN,
  input wire logic [3:0] ROUTE_ON,
  input wire logic [3:0] PRE_MUTE,
  input wire logic [6:0] MON_TRIM,
  input wire logic [3:0] DISP_CODE,
  input wire logic [1:0] LED_LEVEL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside its cycle");
  a_mute_follows: assert property ($rose(EXT_PHANTOM[0]) |-> ##[2:6] PRE_MUTE[0])
    else $error("faulted preamp not muted");
  a_fault_unroute: assert property ($rose(PRE_MUTE[0]) |-> ##[0:2] !ROUTE_ON[0])
    else $error("faulted preamp still routed");
  // The code may start in the dark half of its blink, up to half a bench second
  a_fault_code: assert property ($rose(PRE_MUTE[0]) |-> ##[0:10] DISP_CODE == 4'h1)
    else $error("fault code not shown");
  a_trim_span: assert property (MON_TRIM <= TRIM_MAX || MON_TRIM >= TRIM_MIN)
    else $error("trim out of range");
  a_level_valid: assert property (!$past(RST) && !$past(RST, 2) && !$past(RST, 3)
    |-> LED_LEVEL != 2'h0)
    else $error("brightness level zero");
  a_phantom_cause: assert property ($changed(PHANTOM_EN) |-> $past(PHANTOM_BTN, 4))
    else $error("phantom changed without phantom button");
  a_phantom_one: assert property ($changed(PHANTOM_EN)
    |-> $onehot(PHANTOM_EN ^ $past(PHANTOM_EN)))
    else $error("phantom changed on more than one input");
  a_menu_dark: assert property (DISP_CODE == 4'h3
    |-> (MIC_LED | PRE_LED) == 4'h0 && !LOCK_LED)
    else $error("LEDs lit while menu shows dashes");
  c_menu: cover property (DISP_CODE == 4'h3);
  c_fault: cover property ($rose(PRE_MUTE[0]));
  c_phantom: cover property ($changed(PHANTOM_EN));
endmodule

bind rsc_top rsc_props #(.SEC_CYCLES(SEC_CYCLES)) u_rsc_props (.CLK(CLK), .RST(RST),
  .PHANTOM_BTN(PHANTOM_BTN), .EXT_PHANTOM(EXT_PHANTOM), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .MIC_LED(MIC_LED), .PRE_LED(PRE_LED), .LOCK_LED(LOCK_LED),
  .PHANTOM_EN(PHANTOM_EN), .ROUTE_ON(ROUTE_ON), .PRE_MUTE(PRE_MUTE),
  .MON_TRIM(MON_TRIM), .DISP_CODE(DISP_CODE), .LED_LEVEL(LED_LEVEL));

// >>> verif/rsc_top_tb.sv
// Self-checking bench of the routing snapshot controller
module rsc_top_tb
  import rsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst = 1'b1;
  logic fb = 1'b1;
  logic [3:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wen = 1'b0;
  logic ren = 1'b0;
  logic [31:0] rdata;
  logic [3:0] ph_en, route_on, disp_code;
  logic [7:0] route_mic, disp_val;
  logic [1:0] mon_pre, led_level;
  logic [6:0] mon_trim;
  logic [3:0] mic_led, pre_led, mute;
  logic lock_led, dp, pl_up, pl_lo, rmode;
  rsc_pin_t pin;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  rsc_user u_rsc_user (.clk(clk), .pin(pin));
  rsc_top #(.SEC_CYCLES(16)) u_rsc_top (.CLK(clk), .RST(rst), .FIRST_BOOT(fb),
    .MIC_BTN(pin.mic), .PRE_BTN(pin.pre), .LOCK_BTN(pin.lock), .PHANTOM_BTN(pin.ph),
    .ENC_PUSH(pin.push), .ENC_A(pin.enc_a), .ENC_B(pin.enc_b), .REMOTE_BTN(pin.remote),
    .EXT_PHANTOM(pin.ext_ph), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wen),
    .REG_RD(ren), .REG_RDATA(rdata), .MIC_LED(mic_led), .PRE_LED(pre_led), .LOCK_LED(lock_led),
    .PHANTOM_EN(ph_en), .ROUTE_ON(route_on), .ROUTE_MIC(route_mic), .PRE_MUTE(mute),
    .MON_PRE(mon_pre), .MON_TRIM(mon_trim), .DISP_CODE(disp_code), .DISP_VAL(disp_val),
    .DISP_DP(dp), .PLUS_UP(pl_up), .PLUS_LO(pl_lo), .LED_LEVEL(led_level), .REMOTE_MODE(rmode));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wen <= 1'b1;
    @(posedge clk);
    wen <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    ren <= 1'b1;
    @(posedge clk);
    ren <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask
  task automatic reset(input logic f);
    @(posedge clk);
    rst <= 1'b1;
    fb <= f;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    fb <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic menu(input int t, input int s);
    u_rsc_user.knob();
    repeat (t) u_rsc_user.turn(1'b1);
    u_rsc_user.knob();
    repeat (s) u_rsc_user.turn(1'b1);
    u_rsc_user.knob();
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Whole run is under a thousand cycles; a hang is cut well beyond that
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    reset(1'b1);
    chk("route_on", 32'(route_on), 32'h0);
    rd(REG_CTRL, 32'h3, "ctrl");
    rd(4'h2, 32'h0, "unmapped");
    wr(REG_CTRL, 32'h4);
    rd(REG_CTRL, 32'h7, "ctrl");
    chk("rmode", 32'(rmode), 32'h1);
    wr(REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk("level", 32'(led_level), 32'h1);
    $display("test registers done");
    u_rsc_user.hit('{mic: 4'h2, default: '0});
    u_rsc_user.hit('{pre: 4'h1, default: '0});
    u_rsc_user.hit('{pre: 4'h4, default: '0});
    chk("route_on", 32'(route_on), 32'h5);
    chk("route_mic", 32'(route_mic), 32'h11);
    chk("mon_pre", 32'(mon_pre), 32'h2);
    chk("mic_led", 32'(mic_led), 32'h2);
    chk("pre_led", 32'(pre_led), 32'h4);
    u_rsc_user.hit('{lock: 1'b1, default: '0});
    chk("lock_led", 32'(lock_led), 32'h1);
    u_rsc_user.hit('{mic: 4'h8, default: '0});
    chk("route_mic", 32'(route_mic), 32'h11);
    u_rsc_user.phant(4'h4);
    rd(REG_STATUS, 32'h404511, "status");
    $display("test routing done");
    menu(1, 1);
    rd(REG_SNAP, 32'h2, "snap");
    menu(2, 1);
    chk("route_on", 32'(route_on), 32'h0);
    chk("phantom", 32'(ph_en), 32'h4);
    reset(1'b0);
    rd(REG_STATUS, 32'h4511, "status");
    u_rsc_user.turn(1'b1);
    chk("trim", 32'(mon_trim), 32'h1);
    chk("plus", 32'({pl_up, pl_lo}), 32'h3);
    rd(REG_TRIM, 32'h1, "trim");
    $display("test snapshots done");
    u_rsc_user.knob();
    chk("disp", 32'(disp_code), 32'h3);
    chk("plus", 32'(pl_up ^ pl_lo), 32'h1);
    repeat (6) u_rsc_user.turn(1'b1);
    chk("entry", 32'(disp_val), 32'h5);
    u_rsc_user.turn(1'b1);
    chk("entry", 32'(disp_val), 32'h0);
    repeat (100) @(posedge clk);
    chk("disp", 32'(disp_code), 32'h0);
    u_rsc_user.knob();
    u_rsc_user.knob();
    chk("disp", 32'(disp_code), 32'h0);
    u_rsc_user.knob();
    u_rsc_user.turn(1'b1);
    u_rsc_user.knob();
    u_rsc_user.turn(1'b1);
    chk("dp", 32'(dp), 32'h1);
    u_rsc_user.knob();
    menu(3, 2);
    rd(REG_SNAP, 32'h0, "snap");
    $display("test menu done");
    u_rsc_user.ext(4'h1);
    repeat (8) @(posedge clk);
    chk("route_on", 32'(route_on), 32'h4);
    chk("mute", 32'(mute), 32'h1);
    // Fault code blinks: wait for its lit half, at most one second
    repeat (16) if (disp_code != 4'h1) @(posedge clk);
    chk("disp", 32'(disp_code), 32'h1);
    u_rsc_user.ext(4'h0);
    repeat (20) @(posedge clk);
    repeat (16) if (disp_code != 4'h1) @(posedge clk);
    chk("disp", 32'(disp_code), 32'h1);
    repeat (60) @(posedge clk);
    chk("disp", 32'(disp_code), 32'h0);
    $display("test fault done");
    close_out();
  end
endmodule

// >>> verif/rsc_user.sv
// User model: panel buttons, encoder and external phantom source
module rsc_user
  import rsc_pkg::*;
(
  input wire logic clk,
  output rsc_pin_t pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = '0;
  // Clean press, long enough to cross the two-flop synchroniser and the edge history flop
  task automatic hit(input rsc_pin_t m);
    @(posedge clk);
    pin <= pin | m;
    repeat (6) @(posedge clk);
    pin <= pin & ~m;
    repeat (6) @(posedge clk);
  endtask
  task automatic knob();
    hit('{push: 1'b1, default: '0});
  endtask
  // Direction line settles a cycle before the counting edge
  task automatic turn(input logic up);
    @(posedge clk);
    pin.enc_b <= ~up;
    hit('{enc_a: 1'b1, default: '0});
  endtask
  task automatic phant(input logic [3:0] mic);
    @(posedge clk);
    pin.ph <= 1'b1;
    repeat (6) @(posedge clk);
    hit('{mic: mic, default: '0});
    pin.ph <= 1'b0;
  endtask
  task automatic ext(input logic [3:0] v);
    @(posedge clk);
    pin.ext_ph <= v;
  endtask
endmodule
